// ===== hw/dcw_pkg.sv
/*
  Package for the drive control word decoder: bit positions, telegram codes, reset values,
  state enumeration and the packed command bundle.
  Assumes the control word arrives already framed, one word per control cycle, with a strobe.
*/
// Overview of operation
// - bit0 low: normal ramp stop, power off
// - bit0 rise: ready, run if bit3 high
// - bit1 low: coast stop immediately
// - bit2 low: quick stop with quick ramp
// - bit3 low: cancel pulses at once
// - bit4 low: ramp output forced zero
// - bit5 low: freeze ramp output
// - bit6 selects ramp down or up
// - bit7 rise acknowledges faults, maybe lockout
// - bit10 low: ignore process data; setpoint_in still reaches setpoint_out
// - bit11 high inverts setpoint sign
// - bit13 raises potentiometer, any telegram
// - bit14 lowers potentiometer, any telegram
// - telegram 20: bit15 selects data set
// - entering telegram 20 keeps bit13/14 meaning
// - lockout holds until bit0 low, bit1/bit2 high and no fault active
package dcw_pkg;
  localparam int unsigned BIT_ON        = 0;
  localparam int unsigned BIT_NO_COAST  = 1;
  localparam int unsigned BIT_NO_QUICK  = 2;
  localparam int unsigned BIT_ENABLE_OP = 3;
  localparam int unsigned BIT_RG_ENABLE = 4;
  localparam int unsigned BIT_RG_RUN    = 5;
  localparam int unsigned BIT_SP_ENABLE = 6;
  localparam int unsigned BIT_ACK       = 7;
  localparam int unsigned BIT_PLC_CTRL  = 10;
  localparam int unsigned BIT_REVERSE   = 11;
  localparam int unsigned BIT_POT_UP    = 13;
  localparam int unsigned BIT_POT_DOWN  = 14;
  localparam int unsigned BIT_SET_SELECT = 15;

  localparam logic [9:0]  TELEGRAM_SPECIAL = 10'h014;
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [15:0] POT_RESET        = 16'h0000;
  localparam logic [15:0] POT_STEP         = 16'h0001;
  localparam logic [15:0] POT_MAX          = 16'h7FFF;
  localparam logic [15:0] POT_MIN          = 16'h8001;

  typedef enum logic [1:0] {
    RAMP_HOLD,
    RAMP_UP,
    RAMP_DOWN_NORMAL,
    RAMP_DOWN_QUICK
  } dcw_ramp_t;

  typedef enum {
    ST_LOCKOUT,
    ST_READY_START,
    ST_READY,
    ST_RUNNING,
    ST_RAMP_STOP,
    ST_QUICK_STOP
  } dcw_state_t;

  typedef struct packed {
    logic      pulse_enable;
    logic      ready;
    logic      lockout;
    logic      coast_active;
    logic      quick_active;
    logic      rg_force_zero;
    logic      rg_freeze;
    dcw_ramp_t ramp_mode;
    logic      fault_ack;
    logic      reverse;
    logic      command_data_set_select;
  } dcw_cmd_t;
endpackage : dcw_pkg

// ===== hw/dcw_pot.sv
/*
  Motorized potentiometer setpoint store: signed 16-bit value stepped up or down on an enable.
  Assumes up and down are already qualified; both at once hold the value.
*/
`timescale 1ns/10ps
module dcw_pot (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        step_en,
  input  wire logic        up,
  input  wire logic        down,
  output logic      [15:0] value
);
  logic [15:0] value_r;
  logic [15:0] value_nxt;

  always_comb begin
    value_nxt = value_r;
    if (step_en && up && !down && ($signed(value_r) < $signed(dcw_pkg::POT_MAX))) begin
      value_nxt = value_r + dcw_pkg::POT_STEP;
    end else if (step_en && down && !up && ($signed(value_r) > $signed(dcw_pkg::POT_MIN))) begin
      value_nxt = value_r - dcw_pkg::POT_STEP;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value_r <= dcw_pkg::POT_RESET;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;
endmodule : dcw_pot

// ===== hw/dcw_decoder.sv
/*
  Drive control word decoder: takes each received control word with bit10 set, tracks the switch-on state
  machine and produces the motor, ramp, setpoint and potentiometer commands.
  Assumes word_valid is a one-cycle strobe on clk, fault_active and standstill come from
  logic on the same clock, and setpoint_in is a signed speed setpoint.
*/
`timescale 1ns/10ps
module dcw_decoder (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            word_valid,
  input  wire logic     [15:0] drive_command_word,
  input  wire logic     [9:0]  telegram_type,
  input  wire logic            fault_active,
  input  wire logic            standstill,
  input  wire logic     [15:0] setpoint_in,
  output dcw_pkg::dcw_cmd_t    cmd,
  output logic          [15:0] setpoint_out,
  output logic          [15:0] pot_setpoint,
  output logic                 pot_up_active,
  output logic                 pot_down_active
);
  logic [15:0]         word_r;
  logic [15:0]         word_nxt;
  logic                prev_on_r;
  logic                prev_on_nxt;
  logic                prev_ack_r;
  logic                prev_ack_nxt;
  logic                pot_map_r;
  logic                pot_map_nxt;
  logic [9:0]          tel_r;
  logic [9:0]          tel_nxt;
  dcw_pkg::dcw_state_t state_r;
  dcw_pkg::dcw_state_t state_nxt;
  dcw_pkg::dcw_cmd_t   cmd_r;
  dcw_pkg::dcw_cmd_t   cmd_nxt;
  logic [15:0]         sp_r;
  logic [15:0]         sp_nxt;
  logic                up_r;
  logic                up_nxt;
  logic                dn_r;
  logic                dn_nxt;
  logic [15:0]         pot_value;
  logic                w_on;
  logic                w_coast_ok;
  logic                w_quick_ok;
  logic                w_enop;
  logic                on_rise;
  logic                ack_rise;
  logic                special;

  // words are only taken while the controller holds control
  always_comb begin
    word_nxt = word_r;
    if (word_valid && drive_command_word[dcw_pkg::BIT_PLC_CTRL]) begin
      word_nxt = drive_command_word;
    end
  end

  // reserved bits 8, 9 and 12 are never decoded
  assign w_on       = word_r[dcw_pkg::BIT_ON];
  assign w_coast_ok = word_r[dcw_pkg::BIT_NO_COAST];
  assign w_quick_ok = word_r[dcw_pkg::BIT_NO_QUICK];
  assign w_enop     = word_r[dcw_pkg::BIT_ENABLE_OP];
  assign on_rise    = w_on && !prev_on_r;
  assign ack_rise   = word_r[dcw_pkg::BIT_ACK] && !prev_ack_r;
  assign special    = (tel_r == dcw_pkg::TELEGRAM_SPECIAL);

  // bit13/14 meaning: kept from previous telegram when switching into the special one
  always_comb begin
    prev_on_nxt  = w_on;
    prev_ack_nxt = word_r[dcw_pkg::BIT_ACK];
    tel_nxt      = telegram_type;
    pot_map_nxt  = pot_map_r;
    if (telegram_type != dcw_pkg::TELEGRAM_SPECIAL) begin
      pot_map_nxt = 1'b1;
    end else if (tel_r != dcw_pkg::TELEGRAM_SPECIAL) begin
      pot_map_nxt = pot_map_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dcw_pkg::ST_LOCKOUT: begin
        if (!w_on && w_coast_ok && w_quick_ok && !fault_active) begin
          state_nxt = dcw_pkg::ST_READY_START;
        end
      end
      dcw_pkg::ST_READY_START: begin
        if (on_rise && w_coast_ok && w_quick_ok) begin
          state_nxt = w_enop ? dcw_pkg::ST_RUNNING : dcw_pkg::ST_READY;
        end
      end
      dcw_pkg::ST_READY: begin
        if (!w_on) begin
          state_nxt = dcw_pkg::ST_READY_START;
        end else if (w_enop) begin
          state_nxt = dcw_pkg::ST_RUNNING;
        end
      end
      dcw_pkg::ST_RUNNING: begin
        if (!w_quick_ok) begin
          state_nxt = dcw_pkg::ST_QUICK_STOP;
        end else if (!w_on) begin
          state_nxt = dcw_pkg::ST_RAMP_STOP;
        end else if (!w_enop) begin
          state_nxt = dcw_pkg::ST_READY;
        end
      end
      dcw_pkg::ST_RAMP_STOP: begin
        if (!w_quick_ok) begin
          state_nxt = dcw_pkg::ST_QUICK_STOP;
        end else if (standstill) begin
          state_nxt = dcw_pkg::ST_READY_START;
        end
      end
      dcw_pkg::ST_QUICK_STOP: begin
        if (standstill) begin
          state_nxt = dcw_pkg::ST_LOCKOUT;
        end
      end
      default: begin
        state_nxt = dcw_pkg::ST_LOCKOUT;
      end
    endcase
    // coast stop, pulse inhibit and faults override any running state
    if (!w_coast_ok || fault_active) begin
      state_nxt = dcw_pkg::ST_LOCKOUT;
    end else if (!w_enop && (state_nxt == dcw_pkg::ST_RAMP_STOP ||
                             state_nxt == dcw_pkg::ST_QUICK_STOP)) begin
      state_nxt = dcw_pkg::ST_READY_START;
    end
    if (ack_rise && w_on) begin
      state_nxt = dcw_pkg::ST_LOCKOUT;
    end
  end

  always_comb begin
    cmd_nxt              = '0;
    cmd_nxt.pulse_enable = (state_nxt == dcw_pkg::ST_RUNNING) ||
                           (state_nxt == dcw_pkg::ST_RAMP_STOP) ||
                           (state_nxt == dcw_pkg::ST_QUICK_STOP);
    cmd_nxt.ready        = (state_nxt != dcw_pkg::ST_LOCKOUT);
    cmd_nxt.lockout      = (state_nxt == dcw_pkg::ST_LOCKOUT);
    cmd_nxt.coast_active = !w_coast_ok;
    cmd_nxt.quick_active = (state_nxt == dcw_pkg::ST_QUICK_STOP);
    cmd_nxt.rg_force_zero = !word_r[dcw_pkg::BIT_RG_ENABLE];
    cmd_nxt.rg_freeze    = !word_r[dcw_pkg::BIT_RG_RUN];
    if (state_nxt == dcw_pkg::ST_QUICK_STOP) begin
      cmd_nxt.ramp_mode = dcw_pkg::RAMP_DOWN_QUICK;
    end else if (state_nxt == dcw_pkg::ST_RAMP_STOP) begin
      cmd_nxt.ramp_mode = dcw_pkg::RAMP_DOWN_NORMAL;
    end else if (!word_r[dcw_pkg::BIT_RG_RUN]) begin
      cmd_nxt.ramp_mode = dcw_pkg::RAMP_HOLD;
    end else if (word_r[dcw_pkg::BIT_SP_ENABLE]) begin
      cmd_nxt.ramp_mode = dcw_pkg::RAMP_UP;
    end else begin
      cmd_nxt.ramp_mode = dcw_pkg::RAMP_DOWN_NORMAL;
    end
    cmd_nxt.fault_ack = ack_rise;
    cmd_nxt.reverse   = word_r[dcw_pkg::BIT_REVERSE];
    cmd_nxt.command_data_set_select = special && word_r[dcw_pkg::BIT_SET_SELECT];
    up_nxt = pot_map_r && word_r[dcw_pkg::BIT_POT_UP];
    dn_nxt = pot_map_r && word_r[dcw_pkg::BIT_POT_DOWN];
    if (word_r[dcw_pkg::BIT_REVERSE]) begin
      sp_nxt = 16'h0000 - setpoint_in;
    end else begin
      sp_nxt = setpoint_in;
    end
  end

  dcw_pot u_pot (
    .clk     (clk),
    .rstn    (rstn),
    .step_en (1'b1),
    .up      (up_r),
    .down    (dn_r),
    .value   (pot_value)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_r     <= dcw_pkg::WORD_RESET;
      prev_on_r  <= 1'b0;
      prev_ack_r <= 1'b0;
      pot_map_r  <= 1'b1;
      tel_r      <= 10'h000;
      state_r    <= dcw_pkg::ST_LOCKOUT;
      cmd_r      <= '0;
      sp_r       <= 16'h0000;
      up_r       <= 1'b0;
      dn_r       <= 1'b0;
    end else begin
      word_r     <= word_nxt;
      prev_on_r  <= prev_on_nxt;
      prev_ack_r <= prev_ack_nxt;
      pot_map_r  <= pot_map_nxt;
      tel_r      <= tel_nxt;
      state_r    <= state_nxt;
      cmd_r      <= cmd_nxt;
      sp_r       <= sp_nxt;
      up_r       <= up_nxt;
      dn_r       <= dn_nxt;
    end
  end

  assign cmd             = cmd_r;
  assign setpoint_out    = sp_r;
  assign pot_setpoint    = pot_value;
  assign pot_up_active   = up_r;
  assign pot_down_active = dn_r;
endmodule : dcw_decoder

// ===== verification/dcw_decoder_sva.sv
/*
  Checker for the control word decoder, seeing only its ports.
  Assumes it is bound to dcw_decoder from the bench top file.
*/
`timescale 1ns/10ps
module dcw_decoder_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        word_valid,
  input wire logic [15:0] drive_command_word,
  input wire logic [15:0] setpoint_in,
  input dcw_pkg::dcw_cmd_t cmd,
  input wire logic [15:0] setpoint_out,
  input wire logic [15:0] pot_setpoint,
  input wire logic        pot_up_active,
  input wire logic        pot_down_active
);
  logic        a1_r, a2_r;
  logic [15:0] w1_r, w2_r;
  // a2_r/w2_r: word accepted two edges ago, the one the outputs now show
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      {a2_r, a1_r, w2_r, w1_r} <= '0;
    else
      {a2_r, a1_r, w2_r, w1_r} <= {a1_r, word_valid & drive_command_word[10], w1_r,
                                   drive_command_word};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_zero; a2_r && !w2_r[4] |-> cmd.rg_force_zero; endproperty
  a_zero: assert property (p_zero) else $error("ramp output not zeroed");
  property p_nopulse; a2_r && !w2_r[3] |-> !cmd.pulse_enable; endproperty
  a_nopulse: assert property (p_nopulse) else $error("pulses not cancelled");
  property p_coast; a2_r && !w2_r[1] |-> cmd.coast_active && !cmd.pulse_enable; endproperty
  a_coast: assert property (p_coast) else $error("coast stop missing");
  property p_freeze; a2_r && !w2_r[5] |-> cmd.rg_freeze; endproperty
  a_freeze: assert property (p_freeze) else $error("ramp output not frozen");
  property p_ignore; $past(rstn) && !a2_r |-> $stable(cmd.reverse); endproperty
  a_ignore: assert property (p_ignore) else $error("dropped word took effect");
  property p_rev;
    $past(rstn) && $stable(setpoint_in) && $stable(cmd.reverse)
      |-> setpoint_out == (cmd.reverse ? 16'h0000 - setpoint_in : setpoint_in);
  endproperty
  a_rev: assert property (p_rev) else $error("setpoint sign wrong");
  property p_pot;
    (pot_up_active && !pot_down_active && pot_setpoint < 16'h7000) [*3]
      |-> pot_setpoint == $past(pot_setpoint) + 16'h0001;
  endproperty
  a_pot: assert property (p_pot) else $error("pot value not rising");
  property p_ack; cmd.fault_ack |=> !cmd.fault_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_lock; cmd.lockout |-> !cmd.pulse_enable ##1 !cmd.pulse_enable; endproperty
  a_lock: assert property (p_lock) else $error("motor on in lockout");
  c_run: cover property (cmd.pulse_enable);
  c_ack: cover property (cmd.fault_ack);
  c_pot: cover property (pot_up_active);
endmodule : dcw_decoder_sva

// ===== verification/dcw_fieldbus_ctrl.sv
/*
  Model of the fieldbus controller sending one control word per request.
  Assumes send is a one-cycle request from the bench; the word line is scrambled when idle.
*/
`timescale 1ns/10ps
module dcw_fieldbus_ctrl (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        send,
  input wire logic [15:0] word_in,
  output logic            word_valid,
  output logic     [15:0] drive_command_word
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_valid <= 1'h0;
      drive_command_word <= 16'h0000;
    end else if (send) begin
      word_valid <= 1'h1;
      drive_command_word <= word_in & 16'hecff;
    end else begin
      word_valid <= 1'h0;
      drive_command_word <= ~drive_command_word;
    end
  end
endmodule : dcw_fieldbus_ctrl

// ===== verification/tb.sv
/*
  Bench top: decoder, controller model and bound checker, one task per scenario.
  Assumes the decoder answers within five cycles of a request to the controller.
*/
`timescale 1ns/10ps
module tb;
  logic clk = 0, rstn = 0, send = 0, fault_active = 0, standstill = 0;
  logic [9:0]  telegram_type = 10'h001;
  logic [15:0] word_in = 16'h0000, setpoint_in = 16'h0123;
  logic [15:0] drive_command_word, setpoint_out, pot_setpoint;
  logic        word_valid, pot_up_active, pot_down_active;
  dcw_pkg::dcw_cmd_t cmd;
  int bad_count = 0, comparisons = 0, cyc = 0, acks = 0;
  dcw_fieldbus_ctrl u_ctrl (
    .clk                (clk),
    .rstn               (rstn),
    .send               (send),
    .word_in            (word_in),
    .word_valid         (word_valid),
    .drive_command_word (drive_command_word)
  );
  dcw_decoder u_dut (
    .clk                (clk),
    .rstn               (rstn),
    .word_valid         (word_valid),
    .drive_command_word (drive_command_word),
    .telegram_type      (telegram_type),
    .fault_active       (fault_active),
    .standstill         (standstill),
    .setpoint_in        (setpoint_in),
    .cmd                (cmd),
    .setpoint_out       (setpoint_out),
    .pot_setpoint       (pot_setpoint),
    .pot_up_active      (pot_up_active),
    .pot_down_active    (pot_down_active)
  );
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cmd.fault_ack === 1'h1) acks++;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end
  task chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tx(logic [15:0] w);
    @(posedge clk);
    send <= 1'h1;
    word_in <= w;
    @(posedge clk);
    send <= 1'h0;
    repeat (5) @(posedge clk);
    #1;
  endtask : tx
  task still(logic v);
    @(posedge clk);
    standstill <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask : still
  task go_run;
    tx(16'h0406);
    tx(16'h040f);
  endtask : go_run
  task t_start;
    chk("lockout", cmd.lockout, 1'h1);
    tx(16'h0406);
    chk("ready", {cmd.ready, cmd.lockout}, 2'h2);
    tx(16'h040f);
    chk("pulse", cmd.pulse_enable, 1'h1);
    tx(16'h0407);
    chk("pulse", cmd.pulse_enable, 1'h0);
    tx(16'h040f);
    chk("pulse", cmd.pulse_enable, 1'h1);
    tx(16'h040e);
    chk("mode", {cmd.ramp_mode, cmd.pulse_enable}, {dcw_pkg::RAMP_DOWN_NORMAL, 1'h1});
    still(1'h1);
    chk("pulse", cmd.pulse_enable, 1'h0);
    still(1'h0);
  endtask : t_start
  task t_stops;
    go_run();
    tx(16'h040d);
    chk("coast", {cmd.coast_active, cmd.pulse_enable}, 2'h2);
    go_run();
    tx(16'h040b);
    chk("quick", {cmd.quick_active, cmd.ramp_mode}, {1'h1, dcw_pkg::RAMP_DOWN_QUICK});
    still(1'h1);
    chk("lockout", cmd.lockout, 1'h1);
    tx(16'h040f);
    chk("pulse", cmd.pulse_enable, 1'h0);
    still(1'h0);
  endtask : t_stops
  task t_ramp;
    go_run();
    tx(16'h047f);
    chk("mode", {cmd.ramp_mode, cmd.rg_force_zero}, {dcw_pkg::RAMP_UP, 1'h0});
    tx(16'h045f);
    chk("freeze", {cmd.rg_freeze, cmd.ramp_mode}, {1'h1, dcw_pkg::RAMP_HOLD});
    tx(16'h046f);
    chk("zero", cmd.rg_force_zero, 1'h1);
    tx(16'h043f);
    chk("mode", cmd.ramp_mode, dcw_pkg::RAMP_DOWN_NORMAL);
  endtask : t_ramp
  task t_dir;
    tx(16'h087f);
    chk("reverse", cmd.reverse, 1'h0);
    tx(16'h0c7f);
    chk("setpoint", setpoint_out, 16'hfedd);
  endtask : t_dir
  task t_pot;
    tx(16'h247f);
    chk("pot_up", {pot_up_active, ~pot_setpoint[15] & |pot_setpoint}, 2'h3);
    chk("pot_val", pot_setpoint, 16'h0003);
    tx(16'h447f);
    repeat (20) @(posedge clk);
    #1;
    chk("pot_down", {pot_down_active, pot_setpoint[15]}, 2'h3);
    chk("pot_val", pot_setpoint, 16'hfff0);
    @(posedge clk);
    telegram_type <= 10'h014;
    tx(16'ha47f);
    chk("set_sel_pot", {cmd.command_data_set_select, pot_up_active}, 2'h3);
    @(posedge clk);
    telegram_type <= 10'h001;
    tx(16'h847f);
    chk("set_sel", cmd.command_data_set_select, 1'h0);
  endtask : t_pot
  task t_ack;
    go_run();
    acks = 0;
    tx(16'h04ff);
    chk("ack_lock", {acks[1:0], cmd.lockout}, 3'h3);
    tx(16'h047e);
    chk("lockout", cmd.lockout, 1'h0);
  endtask : t_ack
  task t_fault;
    go_run();
    @(posedge clk);
    fault_active <= 1'h1;
    tx(16'h0406);
    chk("fault", {cmd.lockout, cmd.pulse_enable}, 2'h2);
    @(posedge clk);
    fault_active <= 1'h0;
    acks = 0;
    tx(16'h0486);
    chk("fault_ack", {acks[1:0], cmd.lockout}, 3'h2);
  endtask : t_fault
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    #1;
    t_start();
    t_stops();
    t_ramp();
    t_dir();
    t_pot();
    t_ack();
    t_fault();
    results();
  end
endmodule : tb
bind dcw_decoder dcw_decoder_sva u_sva (
  .clk                (clk),
  .rstn               (rstn),
  .word_valid         (word_valid),
  .drive_command_word (drive_command_word),
  .setpoint_in        (setpoint_in),
  .cmd                (cmd),
  .setpoint_out       (setpoint_out),
  .pot_setpoint       (pot_setpoint),
  .pot_up_active      (pot_up_active),
  .pot_down_active    (pot_down_active)
);
